// ===== hdl/vfe_pkg.sv
// Purpose: Shared constants of the video front end sync and config block.
// Assumes: One 20 MHz clock; registers are 32-bit words on Avalon-MM.
// Notes:   All fields live in byte lane 0; upper bits read as zero.
package vfe_pkg;
  // ----------
  // Register byte offsets
  // ----------
  localparam logic [4:0] OFS_IDENTITY     = 5'h00;
  localparam logic [4:0] OFS_ACTIVITY     = 5'h04;
  localparam logic [4:0] OFS_POLARITY     = 5'h08;
  localparam logic [4:0] OFS_LINE_SLICER  = 5'h0c;
  localparam logic [4:0] OFS_GREEN_SLICER = 5'h10;
  localparam logic [4:0] OFS_INPUT_CFG    = 5'h14;
  // ----------
  // Field positions
  // ----------
  localparam int POS_REVISION   = 0;
  localparam int POS_PART       = 4;
  localparam int POS_PLL_LOCK   = 6;
  localparam int POS_COMBINED   = 7;
  localparam int POS_THREE_A    = 4;
  localparam int POS_THREE_B    = 5;
  localparam int POS_LTHR_A     = 0;
  localparam int POS_LTHR_B     = 4;
  localparam int POS_GLITCH_OFF = 7;
  localparam int POS_GTHR       = 0;
  localparam int POS_LOWPASS    = 4;
  localparam int POS_HYST_OFF   = 5;
  localparam int POS_PORT_SEL   = 0;
  localparam int POS_DC         = 1;
  localparam int POS_COMPONENT  = 2;
  localparam int POS_SYNC_TYPE  = 3;
  localparam int POS_ORIGIN     = 4;
  // ----------
  // Reset values, masks and targets
  // ----------
  localparam logic [7:0] RST_LINE_SLICER  = 8'h33;
  localparam logic [7:0] RST_GREEN_SLICER = 8'h26;
  localparam logic [7:0] RST_INPUT_CFG    = 8'h00;
  localparam logic [7:0] MASK_LINE_SLICER = 8'hf7;
  localparam logic [7:0] MASK_GREEN       = 8'h3f;
  localparam logic [7:0] MASK_INPUT_CFG   = 8'h1f;
  localparam logic [7:0] TARGET_BLACK     = 8'h00;
  localparam logic [7:0] TARGET_CHROMA    = 8'h80;
  // ----------
  // Timing
  // ----------
  localparam int CLK_PERIOD_NS       = 50;
  localparam int ACTIVITY_TIMEOUT_US = 100;
  localparam int ACTIVITY_TIMEOUT_CYC = (ACTIVITY_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int IDLE_W              = 12;
  localparam int RUN_W               = 16;
  localparam int NUM_PROBES          = 6;
  // ----------
  // Bus slave states
  // ----------
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;
endpackage : vfe_pkg

// ===== hdl/sync_probe_if.sv
// Purpose: Carries one sync input to its activity monitor and back.
// Assumes: Owner and monitor share i_clk.
// Notes:   One instance per monitored sync input.
`timescale 1ns/1ps
`default_nettype none
interface sync_probe_if;
  logic sync_level;
  logic filter_off;
  logic present;
  logic low_active;
  modport owner   (output sync_level, output filter_off, input present, input low_active);
  modport monitor (input sync_level, input filter_off, output present, output low_active);
endinterface : sync_probe_if
`default_nettype wire

// ===== hdl/sync_activity_monitor.sv
// Purpose: Decides whether a sync input toggles and which phase is the pulse.
// Assumes: The sync level is synchronous to i_clk.
// Notes:   Optional two-sample glitch filter ahead of edge detection.
`timescale 1ns/1ps
`default_nettype none
module sync_activity_monitor (
  input  wire logic      i_clk,
  input  wire logic      i_srst,
  sync_probe_if.monitor  probe
);
  logic                       prev;
  logic                       filt;
  logic [vfe_pkg::IDLE_W-1:0] idle;
  logic [vfe_pkg::RUN_W-1:0]  run;
  logic [vfe_pkg::RUN_W-1:0]  last_low;
  logic                       present;
  logic                       low_active;
  logic                       next_filt;
  logic [vfe_pkg::IDLE_W-1:0] next_idle;
  logic [vfe_pkg::RUN_W-1:0]  next_run;
  logic [vfe_pkg::RUN_W-1:0]  next_last_low;
  logic                       next_present;
  logic                       next_low_active;

  // Filter, edge timing, activity timeout and pulse polarity.
  always_comb begin
    next_filt       = filt;
    next_idle       = idle;
    next_run        = run;
    next_last_low   = last_low;
    next_present    = present;
    next_low_active = low_active;
    if (probe.filter_off || (probe.sync_level == prev)) begin
      next_filt = probe.sync_level; // R8
    end
    if (next_filt != filt) begin
      next_idle    = '0;
      next_run     = '0;
      next_present = 1'b1; // R2
      if (next_filt) begin
        next_last_low = run;
      end else begin
        next_low_active = (run > last_low); // R5
      end
    end else begin
      if (run != '1) begin
        next_run = run + 1'b1;
      end
      if (idle >= vfe_pkg::IDLE_W'(vfe_pkg::ACTIVITY_TIMEOUT_CYC - 1)) begin
        next_present = 1'b0; // R2
      end else begin
        next_idle = idle + 1'b1;
      end
    end
  end

  // Registers of the monitor.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev       <= probe.sync_level; // No false edge.
      filt       <= probe.sync_level;
      idle       <= '0;
      run        <= '0;
      last_low   <= '0;
      present    <= 1'b0;
      low_active <= 1'b0;
    end else begin
      prev       <= probe.sync_level;
      filt       <= next_filt;
      idle       <= next_idle;
      run        <= next_run;
      last_low   <= next_last_low;
      present    <= next_present;
      low_active <= next_low_active;
    end
  end

  assign probe.present    = present;
  assign probe.low_active = low_active;
endmodule : sync_activity_monitor
`default_nettype wire

// ===== hdl/video_frontend_sync_config.sv
// Purpose: Register set of a video analog front end: identity, sync
//          activity and polarity status, slicer and input configuration.
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 20 MHz clock.
// Notes:   Analog status (lock, combined sync, three-level) arrives as pins.
//
// Summary of operation
// R1: Identity is read-only: revision 3..0, part code 7..4.
// R2: Activity bits 0..5 read 1 while their sync toggles.
// R3: Activity bit 6 reads 1 while the pixel loop is locked.
// R4: Activity bit 7 reads 1 while combined sync is seen.
// R5: Polarity bits 0..3 read 1 for an active-low sync.
// R6: Polarity bits 4 and 5 read 1 for a three-level line sync.
// R7: Line thresholds sit in bits 2..0 and 6..4, 011 after reset.
// R8: Line slicer bit 7 set turns the glitch filter off.
// R9: Green threshold sits in bits 3..0, 0x6 after reset.
// R10: Green slicer bit 4 set turns the low-pass filter on.
// R11: Green slicer bit 5 set turns hysteresis off, 1 after reset.
// R12: Input bit 1 set selects DC coupling and stops the clamp.
// R13: Input bit 2 set selects component, chroma target 0x80.
// R14: Input bit 3 set selects a combined sync.
// R15: Input bit 4 picks line (1) or green (0) source, only with bit 3 set.
// R16: Writes to read-only words leave their contents unchanged.
// R17: Reserved bits read as zero and ignore writes.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module video_frontend_sync_config #(
  parameter logic [3:0] SILICON_REVISION = 4'h1, // Arbitrary value.
  parameter logic [3:0] PART_CODE        = 4'h2  // Arbitrary value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Avalon-MM slave.
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Sync inputs of both input ports.
  input  wire logic        i_line_sync_a,
  input  wire logic        i_line_sync_b,
  input  wire logic        i_frame_sync_a,
  input  wire logic        i_frame_sync_b,
  input  wire logic        i_green_sync_a,
  input  wire logic        i_green_sync_b,
  // Analog status and timing.
  input  wire logic        i_pll_locked,
  input  wire logic        i_combined_sync_seen,
  input  wire logic        i_line_sync_a_three_level,
  input  wire logic        i_line_sync_b_three_level,
  input  wire logic        i_clamp_window,
  // Analog controls.
  output logic [2:0]       o_line_sync_a_threshold,
  output logic [2:0]       o_line_sync_b_threshold,
  output logic             o_glitch_filter_off,
  output logic [3:0]       o_green_sync_threshold,
  output logic             o_green_sync_lowpass_on,
  output logic             o_green_sync_hysteresis_off,
  output logic             o_input_port_select,
  output logic             o_dc_coupling_select,
  output logic             o_clamp_enable,
  output logic             o_component_colour_select,
  output logic [7:0]       o_target_luma,
  output logic [7:0]       o_target_chroma,
  output logic             o_selected_sync
);

  // ----------
  // Declarations
  // ----------
  vfe_pkg::bus_state_e state;
  vfe_pkg::bus_state_e next_state;
  logic [31:0]         rd_word;
  logic [31:0]         readdata;
  logic [31:0]         next_readdata;
  logic [7:0]          line_sync_slicer_config;
  logic [7:0]          green_sync_slicer_config;
  logic [7:0]          input_config;
  logic [7:0]          next_line_slicer;
  logic [7:0]          next_green_slicer;
  logic [7:0]          next_input_cfg;
  logic [7:0]          sync_activity_status;
  logic [7:0]          sync_polarity_status;
  logic [7:0]          next_activity;
  logic [7:0]          next_polarity;
  logic [7:0]          frontend_identity;
  logic                request;
  logic                write_take;
  logic                lane0;
  logic                line_sync_input;
  logic                green_sync_input;
  logic                next_selected_sync;
  logic                next_clamp;
  logic [7:0]          next_chroma;
  logic [vfe_pkg::NUM_PROBES-1:0] raw_sync;
  logic [vfe_pkg::NUM_PROBES-1:0] present;
  logic [vfe_pkg::NUM_PROBES-1:0] low_active;

  // ----------
  // Sync activity monitors
  // ----------

  // Probe order matches the activity bit order.
  assign raw_sync = {i_green_sync_b, i_green_sync_a,
                     i_frame_sync_b, i_frame_sync_a,
                     i_line_sync_b,  i_line_sync_a};

  sync_probe_if probe [vfe_pkg::NUM_PROBES] ();

  // One monitor per sync input; green syncs bypass the line/frame filter.
  genvar g;
  generate
    for (g = 0; g < vfe_pkg::NUM_PROBES; g++) begin : g_probe
      assign probe[g].sync_level = raw_sync[g];
      if (g < 4) begin : g_filtered
        assign probe[g].filter_off = o_glitch_filter_off; // R8
      end else begin : g_unfiltered
        assign probe[g].filter_off = 1'b1;
      end
      assign present[g]    = probe[g].present;
      assign low_active[g] = probe[g].low_active;
      sync_activity_monitor u_monitor (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .probe  (probe[g])
      );
    end
  endgenerate

  // ----------
  // Status words
  // ----------

  // Fixed identity word; no write path reaches it.
  assign frontend_identity = {PART_CODE, SILICON_REVISION}; // R1 R16

  // Collect status each cycle from monitors and analog pins.
  always_comb begin
    next_activity = '0;
    next_activity[5:0] = present; // R2
    next_activity[vfe_pkg::POS_PLL_LOCK] = i_pll_locked; // R3
    next_activity[vfe_pkg::POS_COMBINED] = i_combined_sync_seen; // R4
    next_polarity = '0; // R17
    next_polarity[3:0] = low_active[3:0]; // R5
    next_polarity[vfe_pkg::POS_THREE_A] = i_line_sync_a_three_level; // R6
    next_polarity[vfe_pkg::POS_THREE_B] = i_line_sync_b_three_level; // R6
  end

  // Status registers follow the hardware only.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync_activity_status <= 8'h00;
      sync_polarity_status <= 8'h00;
    end else begin
      sync_activity_status <= next_activity;
      sync_polarity_status <= next_polarity;
    end
  end

  // ----------
  // Avalon-MM slave
  // ----------

  // The request is held until waitrequest is seen low.
  assign request    = i_avs_read | i_avs_write;
  assign write_take = i_avs_write & (state == vfe_pkg::BUS_ANSWER);
  assign lane0      = i_avs_byteenable[0];

  // Waitrequest drops in the answer cycle, one cycle after the request.
  assign o_avs_waitrequest = request & (state != vfe_pkg::BUS_ANSWER);
  assign o_avs_readdata    = readdata;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (i_avs_address)
      vfe_pkg::OFS_IDENTITY:     rd_word[7:0] = frontend_identity; // R1
      vfe_pkg::OFS_ACTIVITY:     rd_word[7:0] = sync_activity_status;
      vfe_pkg::OFS_POLARITY:     rd_word[7:0] = sync_polarity_status;
      vfe_pkg::OFS_LINE_SLICER:  rd_word[7:0] = line_sync_slicer_config;
      vfe_pkg::OFS_GREEN_SLICER: rd_word[7:0] = green_sync_slicer_config;
      vfe_pkg::OFS_INPUT_CFG:    rd_word[7:0] = input_config;
      default:                   rd_word = 32'h0000_0000; // R17
    endcase
  end

  // Bus state and captured read data.
  always_comb begin
    next_state    = state;
    next_readdata = readdata;
    unique case (state)
      vfe_pkg::BUS_IDLE: begin
        if (request) begin
          next_state = vfe_pkg::BUS_ANSWER;
          if (i_avs_read) begin
            next_readdata = rd_word;
          end
        end
      end
      vfe_pkg::BUS_ANSWER: begin
        next_state = vfe_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus registers.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state    <= vfe_pkg::BUS_IDLE;
      readdata <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      readdata <= next_readdata;
    end
  end

  // ----------
  // Writable configuration
  // ----------

  // Only the three configuration words take writes, through lane 0.
  always_comb begin
    next_line_slicer  = line_sync_slicer_config;
    next_green_slicer = green_sync_slicer_config;
    next_input_cfg    = input_config;
    if (write_take && lane0) begin
      unique case (i_avs_address)
        vfe_pkg::OFS_LINE_SLICER: begin
          next_line_slicer = i_avs_writedata[7:0] & vfe_pkg::MASK_LINE_SLICER; // R7 R8 R17
        end
        vfe_pkg::OFS_GREEN_SLICER: begin
          next_green_slicer = i_avs_writedata[7:0] & vfe_pkg::MASK_GREEN; // R9 R10 R11 R17
        end
        vfe_pkg::OFS_INPUT_CFG: begin
          next_input_cfg = i_avs_writedata[7:0] & vfe_pkg::MASK_INPUT_CFG; // R17
        end
        default: begin
          next_input_cfg = input_config; // R16
        end
      endcase
    end
  end

  // Configuration registers with their documented reset codes.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      line_sync_slicer_config  <= vfe_pkg::RST_LINE_SLICER; // R7 R8
      green_sync_slicer_config <= vfe_pkg::RST_GREEN_SLICER; // R9 R11
      input_config             <= vfe_pkg::RST_INPUT_CFG;
    end else begin
      line_sync_slicer_config  <= next_line_slicer;
      green_sync_slicer_config <= next_green_slicer;
      input_config             <= next_input_cfg;
    end
  end

  // ----------
  // Analog controls and sync routing
  // ----------

  // The selected input port supplies line and green syncs.
  assign line_sync_input  = input_config[vfe_pkg::POS_PORT_SEL] ? i_line_sync_b
                                                                : i_line_sync_a;
  assign green_sync_input = input_config[vfe_pkg::POS_PORT_SEL] ? i_green_sync_b
                                                                : i_green_sync_a;

  // Sync multiplexer, clamp gate and chroma target.
  always_comb begin
    next_selected_sync = line_sync_input; // R15
    if (input_config[vfe_pkg::POS_SYNC_TYPE]) begin
      next_selected_sync = input_config[vfe_pkg::POS_ORIGIN] ? line_sync_input
                                                             : green_sync_input; // R14 R15
    end
    next_clamp = ~input_config[vfe_pkg::POS_DC] & i_clamp_window; // R12
    next_chroma = input_config[vfe_pkg::POS_COMPONENT] ? vfe_pkg::TARGET_CHROMA
                                                       : vfe_pkg::TARGET_BLACK; // R13
  end

  // Output flops drive the analog side from the configuration registers and from the clamp window and sync pins.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_line_sync_a_threshold     <= 3'h0;
      o_line_sync_b_threshold     <= 3'h0;
      o_glitch_filter_off         <= 1'b0;
      o_green_sync_threshold      <= 4'h0;
      o_green_sync_lowpass_on     <= 1'b0;
      o_green_sync_hysteresis_off <= 1'b0;
      o_input_port_select         <= 1'b0;
      o_dc_coupling_select        <= 1'b0;
      o_clamp_enable              <= 1'b0;
      o_component_colour_select   <= 1'b0;
      o_target_luma               <= vfe_pkg::TARGET_BLACK;
      o_target_chroma             <= vfe_pkg::TARGET_BLACK;
      o_selected_sync             <= 1'b0;
    end else begin
      o_line_sync_a_threshold     <= line_sync_slicer_config[vfe_pkg::POS_LTHR_A +: 3]; // R7
      o_line_sync_b_threshold     <= line_sync_slicer_config[vfe_pkg::POS_LTHR_B +: 3]; // R7
      o_glitch_filter_off         <= line_sync_slicer_config[vfe_pkg::POS_GLITCH_OFF]; // R8
      o_green_sync_threshold      <= green_sync_slicer_config[vfe_pkg::POS_GTHR +: 4]; // R9
      o_green_sync_lowpass_on     <= green_sync_slicer_config[vfe_pkg::POS_LOWPASS]; // R10
      o_green_sync_hysteresis_off <= green_sync_slicer_config[vfe_pkg::POS_HYST_OFF]; // R11
      o_input_port_select         <= input_config[vfe_pkg::POS_PORT_SEL];
      o_dc_coupling_select        <= input_config[vfe_pkg::POS_DC]; // R12
      o_clamp_enable              <= next_clamp; // R12
      o_component_colour_select   <= input_config[vfe_pkg::POS_COMPONENT]; // R13
      o_target_luma               <= vfe_pkg::TARGET_BLACK; // R13
      o_target_chroma             <= next_chroma; // R13
      o_selected_sync             <= next_selected_sync; // R14
    end
  end

endmodule : video_frontend_sync_config
`default_nettype wire

// ===== tb/vfe_video_src.sv
// Purpose: Video source model driving the six sync inputs.
// Assumes: Levels change just after a rising clock edge.
// Notes:   An idle input rests at its inactive level.
`timescale 1ns/1ps
`default_nettype none
module vfe_video_src (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_run,
  input  wire logic [5:0] i_low,
  input  wire logic       i_glitch,
  output logic      [5:0] o_sync
);
  logic [3:0] phase = 4'h0;

  // Line timing: 16 cycles per period.
  always_ff @(posedge i_clk) begin
    phase <= phase + 4'h1;
  end

  // Three-cycle pulses, inverted for low-active inputs; a stray spike stands one cycle.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      o_sync[k] = i_low[k] ^ ((i_run[k] && phase < 4'h3) || (i_glitch && phase == 4'h8));
    end
  end
endmodule : vfe_video_src
`default_nettype wire

// ===== tb/video_frontend_sync_config_monitor.sv
// Purpose: Port assertions of the front end register block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Status pins reach read data two edges later.
`timescale 1ns/1ps
`default_nettype none
module video_frontend_sync_config_monitor #(
  parameter logic [3:0] SILICON_REVISION = 4'h1,
  parameter logic [3:0] PART_CODE        = 4'h2
) (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_pll_locked,
  input wire logic        i_combined_sync_seen,
  input wire logic        i_line_sync_a_three_level,
  input wire logic        i_line_sync_b_three_level,
  input wire logic        i_clamp_window,
  input wire logic [2:0]  o_line_sync_a_threshold,
  input wire logic [2:0]  o_line_sync_b_threshold,
  input wire logic        o_glitch_filter_off,
  input wire logic [3:0]  o_green_sync_threshold,
  input wire logic        o_green_sync_hysteresis_off,
  input wire logic        o_dc_coupling_select,
  input wire logic        o_clamp_enable,
  input wire logic        o_component_colour_select,
  input wire logic [7:0]  o_target_luma,
  input wire logic [7:0]  o_target_chroma
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // A read answered at one word.
  sequence s_rd(logic [4:0] a);
    i_avs_read && !o_avs_waitrequest && i_avs_address == a;
  endsequence

  // Control outputs as they stand after reset.
  sequence s_defaults;
    o_line_sync_a_threshold == 3'h3 && o_line_sync_b_threshold == 3'h3 && !o_glitch_filter_off
    && o_green_sync_threshold == 4'h6 && o_green_sync_hysteresis_off;
  endsequence

  // Checks on configuration outputs and read data.
  default_cfg_a: assert property ($fell(i_srst) |=> s_defaults)
    else $error("reset defaults wrong");
  clamp_follow_a: assert property (!$past(i_srst) |-> o_clamp_enable ==
    (!o_dc_coupling_select && $past(i_clamp_window))) else $error("clamp wrong");
  dc_noclamp_a: assert property (o_dc_coupling_select |-> !o_clamp_enable)
    else $error("clamp under dc");
  chroma_target_a: assert property (o_target_chroma ==
    (o_component_colour_select ? 8'h80 : 8'h00)) else $error("chroma target wrong");
  luma_target_a: assert property (o_target_luma == 8'h00)
    else $error("luma target wrong");
  status_read_a: assert property (s_rd(vfe_pkg::OFS_ACTIVITY) |-> o_avs_readdata[7:6] ==
    {$past(i_combined_sync_seen, 2), $past(i_pll_locked, 2)}) else $error("status wrong");
  ident_read_a: assert property (s_rd(vfe_pkg::OFS_IDENTITY) |-> o_avs_readdata ==
    {24'h0, PART_CODE, SILICON_REVISION}) else $error("identity wrong");
  three_level_a: assert property (s_rd(vfe_pkg::OFS_POLARITY) |-> o_avs_readdata[31:4] ==
    {26'h0, $past(i_line_sync_b_three_level, 2), $past(i_line_sync_a_three_level, 2)})
    else $error("three-level wrong");
  upper_zero_a: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h0) else $error("reserved bits set");
endmodule : video_frontend_sync_config_monitor

bind video_frontend_sync_config video_frontend_sync_config_monitor #(
  .SILICON_REVISION(SILICON_REVISION),
  .PART_CODE(PART_CODE)
) u_video_frontend_sync_config_monitor (.*);
`default_nettype wire

// ===== tb/video_frontend_sync_config_tb.sv
// Purpose: Self-checking bench of the front end register block.
// Assumes: 20 MHz clock; Avalon-MM master tasks.
// Notes:   Syncs come from the video source model.
`timescale 1ns/1ps
`default_nettype none
module video_frontend_sync_config_tb;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [4:0]  i_avs_address = 5'h00;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic [5:0]  run = 6'h00;
  logic [5:0]  low = 6'h00;
  logic        glitch = 1'b0;
  logic [5:0]  sync;
  logic        pll = 1'b0;
  logic        comb = 1'b0;
  logic        tri_a = 1'b0;
  logic        win = 1'b0;
  logic [2:0]  thr_a, thr_b;
  logic [3:0]  gthr;
  logic [7:0]  luma, chroma;
  logic        glf, lpf, hyo, port, dc, clamp, comp, ssel;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // Clock and a hang guard.
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      results();
    end
  end

  vfe_video_src u_vfe_video_src (.i_clk(i_clk), .i_run(run), .i_low(low), .i_glitch(glitch),
    .o_sync(sync));

  video_frontend_sync_config #(.SILICON_REVISION(4'h5), .PART_CODE(4'ha))
  u_video_frontend_sync_config (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_line_sync_a(sync[0]), .i_line_sync_b(sync[1]), .i_frame_sync_a(sync[2]),
    .i_frame_sync_b(sync[3]), .i_green_sync_a(sync[4]), .i_green_sync_b(sync[5]),
    .i_pll_locked(pll), .i_combined_sync_seen(comb), .i_line_sync_a_three_level(tri_a),
    .i_line_sync_b_three_level(1'b0), .i_clamp_window(win),
    .o_line_sync_a_threshold(thr_a), .o_line_sync_b_threshold(thr_b),
    .o_glitch_filter_off(glf), .o_green_sync_threshold(gthr), .o_green_sync_lowpass_on(lpf),
    .o_green_sync_hysteresis_off(hyo), .o_input_port_select(port),
    .o_dc_coupling_select(dc), .o_clamp_enable(clamp), .o_component_colour_select(comp),
    .o_target_luma(luma), .o_target_chroma(chroma), .o_selected_sync(ssel));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0);
    r = rdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    chk("wait edges", 32'h2, 32'(n));
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rdc

  task automatic t_reset;
    rdc("identity", vfe_pkg::OFS_IDENTITY, 32'ha5);
    rdc("line slicer", vfe_pkg::OFS_LINE_SLICER, 32'h33);
    rdc("green slicer", vfe_pkg::OFS_GREEN_SLICER, 32'h26);
    rdc("unmapped", 5'h18, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(5'(4 * k), 32'hffffffff);
    end
    rdc("identity", vfe_pkg::OFS_IDENTITY, 32'ha5);
    rdc("activity", vfe_pkg::OFS_ACTIVITY, 32'h0);
    rdc("polarity", vfe_pkg::OFS_POLARITY, 32'h0);
  endtask : t_reset

  task automatic t_rw;
    logic [31:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 32'h0 : 32'hffffffff;
      wr(vfe_pkg::OFS_LINE_SLICER, v);
      wr(vfe_pkg::OFS_GREEN_SLICER, v);
      rdc("line slicer", vfe_pkg::OFS_LINE_SLICER, v & 32'hf7);
      rdc("green slicer", vfe_pkg::OFS_GREEN_SLICER, v & 32'h3f);
      chk("controls", v & 32'h1fff, {19'h0, thr_a, thr_b, glf, gthr, lpf, hyo});
    end
    wr(vfe_pkg::OFS_LINE_SLICER, 32'h33);
  endtask : t_rw

  task automatic t_status;
    @(posedge i_clk);
    run <= 6'h3f;
    low <= 6'h05;
    pll <= 1'b1;
    comb <= 1'b1;
    tri_a <= 1'b1;
    repeat (80) @(posedge i_clk);
    rdc("activity", vfe_pkg::OFS_ACTIVITY, 32'hff);
    rdc("polarity", vfe_pkg::OFS_POLARITY, 32'h15);
    run <= 6'h00;
    pll <= 1'b0;
    comb <= 1'b0;
    tri_a <= 1'b0;
    repeat (2100) @(posedge i_clk);
    rdc("activity", vfe_pkg::OFS_ACTIVITY, 32'h0);
  endtask : t_status

  task automatic t_glitch;
    glitch <= 1'b1;
    repeat (100) @(posedge i_clk);
    rdc("filtered", vfe_pkg::OFS_ACTIVITY, 32'h30);
    wr(vfe_pkg::OFS_LINE_SLICER, 32'hb3);
    repeat (100) @(posedge i_clk);
    rdc("unfiltered", vfe_pkg::OFS_ACTIVITY, 32'h3f);
    glitch <= 1'b0;
    wr(vfe_pkg::OFS_LINE_SLICER, 32'h33);
  endtask : t_glitch

  task automatic t_mux;
    logic [4:0] c;
    logic       ln;
    logic       e;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wr(vfe_pkg::OFS_INPUT_CFG, {27'h0, c} | 32'he0);
      rdc("input cfg", vfe_pkg::OFS_INPUT_CFG, {27'h0, c});
      for (int p = 0; p < 2; p++) begin
        @(posedge i_clk);
        low <= p ? 6'h21 : 6'h12;
        win <= p[0];
        repeat (3) @(posedge i_clk);
        ln = c[0] ? low[1] : low[0];
        e = (c[3] && !c[4]) ? (c[0] ? low[5] : low[4]) : ln;
        chk("routing", {11'h0, e, !c[1] && win, c[2] ? 8'h80 : 8'h00, 8'h00, c[2:0]},
            {11'h0, ssel, clamp, chroma, luma, comp, dc, port});
      end
    end
  endtask : t_mux

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_rw();
    t_status();
    t_glitch();
    t_mux();
    results();
  end
endmodule : video_frontend_sync_config_tb
`default_nettype wire
